// ### core/chgi2c_target.sv
// Charger register port: two-wire target with an auto-incrementing pointer.
// Assumes the serial lines are asynchronous to clk_i and come from chgi2c_if.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module chgi2c_target (
    input wire logic clk_i,
    input wire logic rst_b_i,
    chgi2c_if.target bus,
    input wire logic int_event_i,
    input wire logic loop_active_i,
    input wire logic [7:0] state_i,
    output logic [1:0] ovp_select_o,
    output logic high_impedance_o,
    output logic hs_mode_o
);
    typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WR, ST_WR_ACK,
                  ST_RD, ST_RD_ACK, ST_SKIP} chgi2c_state_t;
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        chgi2c_state_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [7:0] ptr;
        logic sda_oe;
        logic hs_pend;
        logic hs;
        logic [7:0] ctl1;
        logic [chgi2c_pkg::NUM_RW-1:0][7:0] rw;
    } chgi2c_tgt_t;
    chgi2c_tgt_t r, nxt;

    function automatic int rw_index(input logic [7:0] a);
        case (a)
            chgi2c_pkg::OFS_CHARGE_CONTROL_TWO: rw_index = 0;
            chgi2c_pkg::OFS_BATTERY_CURRENT_SETTING: rw_index = 1;
            chgi2c_pkg::OFS_FLOAT_VOLTAGE_SETTING: rw_index = 2;
            chgi2c_pkg::OFS_INPUT_CURRENT_SETTING: rw_index = 3;
            chgi2c_pkg::OFS_INTERRUPT_FLAG_MASK: rw_index = 4;
            chgi2c_pkg::OFS_STATUS_MASK: rw_index = 5;
            chgi2c_pkg::OFS_SAFETY: rw_index = 6;
            chgi2c_pkg::OFS_TIMER_CONTROL: rw_index = 7;
            default: rw_index = -1;
        endcase
    endfunction : rw_index

    function automatic logic [7:0] rw_default(input int i);
        case (i)
            0: rw_default = chgi2c_pkg::CTL2_RESET;
            1: rw_default = chgi2c_pkg::BATTERY_CURRENT_SETTING_RESET;
            default: rw_default = chgi2c_pkg::RW_RESET;
        endcase
    endfunction : rw_default

    function automatic logic [7:0] read_reg(input chgi2c_tgt_t s, input logic [7:0] a,
                                            input logic [7:0] st);
        int i;
        i = rw_index(a);
        if (a == chgi2c_pkg::OFS_CHIP_IDENTITY) begin
            read_reg = {chgi2c_pkg::SUPPLIER_CODE, chgi2c_pkg::PART_NUMBER_BITS,
                        chgi2c_pkg::REVISION};
        end else if (a == chgi2c_pkg::OFS_CHARGE_CONTROL_ONE) begin
            read_reg = s.ctl1 & 8'h57;
        end else if (a == chgi2c_pkg::OFS_STATE) begin
            read_reg = st;
        end else if (i >= 0) begin
            read_reg = s.rw[i];
        end else begin
            read_reg = 8'h00;
        end
    endfunction : read_reg

    logic rise, fall, start_c, stop_c, sda_in;

    always_comb begin
        int wi;
        wi = -1;
        nxt = r;
        nxt.scl_s = {r.scl_s[1:0], bus.scl};
        nxt.sda_s = {r.sda_s[1:0], bus.sda};
        sda_in = r.sda_s[1];
        rise = r.scl_s[1] & ~r.scl_s[2];
        fall = ~r.scl_s[1] & r.scl_s[2];
        start_c = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
        stop_c = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];
        nxt.ctl1[chgi2c_pkg::CTL1_LOOP_BIT] = loop_active_i;
        if (int_event_i) begin
            nxt.ctl1[chgi2c_pkg::CTL1_INT_BIT] = 1'b1;
        end
        if (stop_c) begin
            nxt.st = ST_IDLE;
            nxt.sda_oe = 1'b0;
            nxt.hs = 1'b0;
            nxt.hs_pend = 1'b0;
        end else if (start_c) begin
            nxt.st = ST_ADDR;
            nxt.cnt = 4'h0;
            nxt.sda_oe = 1'b0;
            if (r.hs_pend) begin
                nxt.hs = 1'b1;
                nxt.hs_pend = 1'b0;
            end
        end else begin
            case (r.st)
                ST_ADDR, ST_REG, ST_WR: begin
                    if (rise) begin
                        nxt.sh = {r.sh[6:0], sda_in};
                        nxt.cnt = r.cnt + 4'h1;
                    end
                    if (fall && r.cnt == 4'h8) begin
                        nxt.cnt = 4'h0;
                        if (r.st == ST_ADDR) begin
                            if (r.sh[7:3] == chgi2c_pkg::HS_CODE_TOP) begin
                                nxt.hs_pend = 1'b1;
                                nxt.st = ST_SKIP;
                            end else if (r.sh[7:1] == chgi2c_pkg::TARGET_ADDR) begin
                                nxt.sda_oe = 1'b1;
                                nxt.st = ST_ADDR_ACK;
                            end else begin
                                nxt.st = ST_SKIP;
                            end
                        end else if (r.st == ST_REG) begin
                            nxt.ptr = r.sh;
                            nxt.sda_oe = 1'b1;
                            nxt.st = ST_REG_ACK;
                        end else begin
                            wi = rw_index(r.ptr);
                            if (r.ptr == chgi2c_pkg::OFS_CHARGE_CONTROL_ONE) begin
                                if (r.sh[chgi2c_pkg::CTL1_SOFT_RESET_BIT]) begin
                                    nxt.ctl1 = chgi2c_pkg::CTL1_RESET;
                                    for (int k = 0; k < chgi2c_pkg::NUM_RW; k++) begin
                                        nxt.rw[k] = rw_default(k);
                                    end
                                end else begin
                                    nxt.ctl1[chgi2c_pkg::CTL1_HIGH_IMPEDANCE_BIT] =
                                        r.sh[chgi2c_pkg::CTL1_HIGH_IMPEDANCE_BIT];
                                    nxt.ctl1[chgi2c_pkg::CTL1_OVP_LSB +: 2] =
                                        r.sh[chgi2c_pkg::CTL1_OVP_LSB +: 2];
                                end
                            end else if (wi >= 0) begin
                                nxt.rw[wi] = r.sh;
                            end
                            nxt.ptr = r.ptr + 8'h01;
                            nxt.sda_oe = 1'b1;
                            nxt.st = ST_WR_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_REG_ACK, ST_WR_ACK: begin
                    if (fall) begin
                        nxt.sda_oe = 1'b0;
                        if (r.st == ST_ADDR_ACK && r.sh[0]) begin
                            nxt.sh = read_reg(r, r.ptr, state_i);
                            nxt.sda_oe = ~nxt.sh[7];
                            nxt.st = ST_RD;
                            if (r.ptr == chgi2c_pkg::OFS_CHARGE_CONTROL_ONE && !int_event_i) begin
                                nxt.ctl1[chgi2c_pkg::CTL1_INT_BIT] = 1'b0;
                            end
                        end else begin
                            nxt.st = (r.st == ST_ADDR_ACK) ? ST_REG : ST_WR;
                        end
                    end
                end
                ST_RD: begin
                    if (fall) begin
                        nxt.cnt = r.cnt + 4'h1;
                        if (r.cnt == 4'h7) begin
                            nxt.sda_oe = 1'b0;
                            nxt.ptr = r.ptr + 8'h01;
                            nxt.st = ST_RD_ACK;
                        end else begin
                            nxt.sh = {r.sh[6:0], 1'b0};
                            nxt.sda_oe = ~r.sh[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (rise && sda_in) begin
                        nxt.st = ST_SKIP;
                    end else if (fall) begin
                        nxt.cnt = 4'h0;
                        nxt.sh = read_reg(r, r.ptr, state_i);
                        nxt.sda_oe = ~nxt.sh[7];
                        nxt.st = ST_RD;
                        if (r.ptr == chgi2c_pkg::OFS_CHARGE_CONTROL_ONE && !int_event_i) begin
                            nxt.ctl1[chgi2c_pkg::CTL1_INT_BIT] = 1'b0;
                        end
                    end
                end
                ST_SKIP: nxt.sda_oe = 1'b0;
                default: nxt.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r.scl_s <= 3'h7;
            r.sda_s <= 3'h7;
            r.st <= ST_IDLE;
            r.sh <= 8'h00;
            r.cnt <= 4'h0;
            r.ptr <= 8'h00;
            r.sda_oe <= 1'b0;
            r.hs_pend <= 1'b0;
            r.hs <= 1'b0;
            r.ctl1 <= chgi2c_pkg::CTL1_RESET;
            for (int k = 0; k < chgi2c_pkg::NUM_RW; k++) begin
                r.rw[k] <= rw_default(k);
            end
        end else begin
            r <= nxt;
        end
    end

    assign bus.sda_oe_t = r.sda_oe;
    assign ovp_select_o = r.ctl1[chgi2c_pkg::CTL1_OVP_LSB +: 2];
    assign high_impedance_o = r.ctl1[chgi2c_pkg::CTL1_HIGH_IMPEDANCE_BIT];
    assign hs_mode_o = r.hs;
endmodule : chgi2c_target

// ### core/chgi2c_pkg.sv
// Shared constants for the charger two-wire register port and its bus master.
// Assumes both ends run on one 125 MHz system clock with an active-low reset.
package chgi2c_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h6b;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam logic [7:0] OFS_CHIP_IDENTITY = 8'h00;
    localparam logic [7:0] OFS_CHARGE_CONTROL_ONE = 8'h01;
    localparam logic [7:0] OFS_CHARGE_CONTROL_TWO = 8'h02;
    localparam logic [7:0] OFS_BATTERY_CURRENT_SETTING = 8'h03;
    localparam logic [7:0] OFS_FLOAT_VOLTAGE_SETTING = 8'h04;
    localparam logic [7:0] OFS_INPUT_CURRENT_SETTING = 8'h05;
    localparam logic [7:0] OFS_INTERRUPT_FLAGS = 8'h06;
    localparam logic [7:0] OFS_STATUS = 8'h07;
    localparam logic [7:0] OFS_INTERRUPT_FLAG_MASK = 8'h08;
    localparam logic [7:0] OFS_STATUS_MASK = 8'h09;
    localparam logic [7:0] OFS_SAFETY_TIMER_RESTART = 8'h0a;
    localparam logic [7:0] OFS_SAFETY = 8'h0f;
    localparam logic [7:0] OFS_MONITOR = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h1f;
    localparam logic [7:0] OFS_ATTACH_DETECT_CONTROL = 8'h20;
    localparam logic [7:0] OFS_ATTACH_DETECT_COUNT = 8'h21;
    localparam logic [7:0] OFS_TIMER_CONTROL = 8'h22;
    localparam int NUM_RW = 8;
    // Identity fields; values arbitrary
    localparam logic [2:0] SUPPLIER_CODE = 3'h5;
    localparam logic [1:0] PART_NUMBER_BITS = 2'h1;
    localparam logic [2:0] REVISION = 3'h0;
    localparam int CTL1_SOFT_RESET_BIT = 7;
    localparam int CTL1_HIGH_IMPEDANCE_BIT = 6;
    localparam int CTL1_LOOP_BIT = 4;
    localparam int CTL1_OVP_LSB = 1;
    localparam int CTL1_INT_BIT = 0;
    localparam logic [7:0] CTL1_RESET = 8'h02;
    localparam logic [7:0] CTL2_RESET = 8'h07;
    localparam logic [7:0] BATTERY_CURRENT_SETTING_RESET = 8'h02;
    localparam logic [7:0] RW_RESET = 8'h00;
    // Master divider: four ticks of SCL_HALF+1 clocks per serial bit, never above SCL_FREQ_KHZ
    localparam int SCL_FREQ_KHZ = 1000;
    localparam int CLK_FREQ_KHZ = 125000;
    localparam int SCL_HALF_CYC = (CLK_FREQ_KHZ + 4 * SCL_FREQ_KHZ - 1) / (4 * SCL_FREQ_KHZ) - 1;
    localparam logic [7:0] SCL_HALF = 8'(SCL_HALF_CYC);
    // Controller register offsets on the software port
    localparam logic [3:0] CR_CMD = 4'h0;
    localparam logic [3:0] CR_REG = 4'h1;
    localparam logic [3:0] CR_WDATA = 4'h2;
    localparam logic [3:0] CR_RDATA = 4'h3;
    localparam logic [3:0] CR_STATUS = 4'h4;
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CMD_HS_BIT = 2;
endpackage : chgi2c_pkg

// ### core/chgi2c_if.sv
// Two-wire bus between the charger port and its master.
// Both lines are open drain: low when any enabled driver pulls, else pulled up.
`timescale 1ns/1ps
interface chgi2c_if;
    logic scl_oe_m;
    logic sda_oe_m;
    logic sda_oe_t;
    logic scl;
    logic sda;
    assign scl = ~scl_oe_m;
    assign sda = ~(sda_oe_m | sda_oe_t);
    modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
    modport target (output sda_oe_t, input scl, input sda);
endinterface : chgi2c_if

// ### core/chgi2c_master.sv
// Bus master for the charger port: one register write or read per command.
// Assumes software on the plain register port; serial clock made by a divider.
`timescale 1ns/1ps
module chgi2c_master (
    input wire logic clk_i,
    input wire logic rst_b_i,
    chgi2c_if.master bus,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o
);
    typedef enum {MS_IDLE, MS_START, MS_BYTE, MS_ACK, MS_RSTART, MS_RBYTE, MS_MACK,
                  MS_STOP} chgi2c_mst_st_t;
    typedef struct packed {
        logic [1:0] sda_s;
        chgi2c_mst_st_t st;
        logic [7:0] div;
        logic [1:0] ph;
        logic [3:0] bit_n;
        logic [1:0] byte_n;
        logic [7:0] sh;
        logic [7:0] reg_a;
        logic [7:0] wdat;
        logic [7:0] rdat;
        logic rd_cmd;
        logic busy;
        logic nack;
        logic scl_oe;
        logic sda_oe;
        logic [7:0] rdata;
    } chgi2c_mst_t;
    chgi2c_mst_t r, nxt;
    logic tick;

    always_comb begin
        nxt = r;
        nxt.sda_s = {r.sda_s[0], bus.sda};
        nxt.rdata = 8'h00;
        tick = (r.div == chgi2c_pkg::SCL_HALF);
        nxt.div = tick ? 8'h00 : r.div + 8'h01;
        if (rd_i) begin
            case (addr_i)
                chgi2c_pkg::CR_REG: nxt.rdata = r.reg_a;
                chgi2c_pkg::CR_WDATA: nxt.rdata = r.wdat;
                chgi2c_pkg::CR_RDATA: nxt.rdata = r.rdat;
                chgi2c_pkg::CR_STATUS: nxt.rdata = {6'h00, r.nack, r.busy};
                default: nxt.rdata = 8'h00;
            endcase
        end
        if (wr_i && !r.busy) begin
            if (addr_i == chgi2c_pkg::CR_REG) nxt.reg_a = wdata_i;
            if (addr_i == chgi2c_pkg::CR_WDATA) nxt.wdat = wdata_i;
            if (addr_i == chgi2c_pkg::CR_CMD && wdata_i[chgi2c_pkg::CMD_GO_BIT]) begin
                nxt.busy = 1'b1;
                nxt.nack = 1'b0;
                nxt.rd_cmd = wdata_i[chgi2c_pkg::CMD_READ_BIT];
                nxt.st = MS_START;
                nxt.ph = 2'h0;
            end
        end
        if (tick && r.busy) begin
            nxt.ph = r.ph + 2'h1;
            case (r.st)
                MS_START, MS_RSTART: begin
                    // Phases: release data and pull clock, release clock, pull data, pull clock
                    case (r.ph)
                        2'h0: begin
                            nxt.sda_oe = 1'b0;
                            nxt.scl_oe = 1'b1;
                        end
                        2'h1: nxt.scl_oe = 1'b0;
                        2'h2: nxt.sda_oe = 1'b1;
                        default: begin
                            nxt.scl_oe = 1'b1;
                            nxt.st = MS_BYTE;
                            nxt.bit_n = 4'h0;
                            nxt.sh = {chgi2c_pkg::TARGET_ADDR, r.st == MS_RSTART};
                            nxt.sda_oe = ~chgi2c_pkg::TARGET_ADDR[6];
                        end
                    endcase
                end
                MS_BYTE, MS_ACK, MS_RBYTE, MS_MACK: begin
                    // Phase 0 drives data, 1 raises clock, 2 samples, 3 lowers clock
                    case (r.ph)
                        2'h0: nxt.sda_oe = (r.st == MS_BYTE) ? ~r.sh[7] :
                                           (r.st == MS_MACK) ? 1'b0 : 1'b0;
                        2'h1: nxt.scl_oe = 1'b0;
                        2'h2: begin
                            if (r.st == MS_RBYTE) nxt.sh = {r.sh[6:0], r.sda_s[1]};
                            if (r.st == MS_ACK && r.sda_s[1]) nxt.nack = 1'b1;
                        end
                        default: begin
                            nxt.scl_oe = 1'b1;
                            if (r.st == MS_BYTE) begin
                                nxt.sh = {r.sh[6:0], 1'b0};
                                nxt.bit_n = r.bit_n + 4'h1;
                                if (r.bit_n == 4'h7) nxt.st = MS_ACK;
                            end else if (r.st == MS_RBYTE) begin
                                nxt.bit_n = r.bit_n + 4'h1;
                                if (r.bit_n == 4'h7) begin
                                    nxt.rdat = r.sh;
                                    nxt.st = MS_MACK;
                                end
                            end else if (r.st == MS_MACK) begin
                                nxt.st = MS_STOP;
                            end else if (r.nack) begin
                                nxt.st = MS_STOP;
                            end else begin
                                nxt.byte_n = r.byte_n + 2'h1;
                                nxt.bit_n = 4'h0;
                                if (r.byte_n == 2'h0) begin
                                    nxt.sh = r.reg_a;
                                    nxt.st = MS_BYTE;
                                end else if (r.byte_n == 2'h1 && r.rd_cmd) begin
                                    nxt.st = MS_RSTART;
                                end else if (r.byte_n == 2'h1) begin
                                    nxt.sh = r.wdat;
                                    nxt.st = MS_BYTE;
                                end else if (r.byte_n == 2'h2 && r.rd_cmd) begin
                                    nxt.sh = 8'h00;
                                    nxt.st = MS_RBYTE;
                                end else begin
                                    nxt.st = MS_STOP;
                                end
                            end
                        end
                    endcase
                    if (r.st == MS_MACK && r.ph == 2'h0) nxt.sda_oe = 1'b0;
                    if ((r.st == MS_ACK || r.st == MS_RBYTE) && r.ph == 2'h0) begin
                        nxt.sda_oe = 1'b0;
                    end
                end
                MS_STOP: begin
                    case (r.ph)
                        2'h0: nxt.sda_oe = 1'b1;
                        2'h1: nxt.scl_oe = 1'b0;
                        2'h2: nxt.sda_oe = 1'b0;
                        default: begin
                            nxt.busy = 1'b0;
                            nxt.byte_n = 2'h0;
                            nxt.st = MS_IDLE;
                        end
                    endcase
                end
                default: nxt.st = MS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= '0;
            r.sda_s <= 2'h3;
            r.st <= MS_IDLE;
        end else begin
            r <= nxt;
        end
    end

    assign bus.scl_oe_m = r.scl_oe;
    assign bus.sda_oe_m = r.sda_oe;
    assign rdata_o = r.rdata;
endmodule : chgi2c_master

// ### verif/chgi2c_props.sv
// Checker for the two-wire link between the charger port and its bus master.
// Assumes the resolved lines and enables of chgi2c_if and the 125 MHz clock.
`timescale 1ns/1ps
module chgi2c_props (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic scl_oe_m,
    input wire logic sda_oe_m,
    input wire logic sda_oe_t,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_start; $fell(sda) && scl && $past(scl); endsequence
    sequence s_stop; $rose(sda) && scl && $past(scl); endsequence
    property p_rst_idle; $rose(rst_b_i) |-> !scl_oe_m && !sda_oe_m && !sda_oe_t; endproperty
    property p_tgt_edge; $changed(sda_oe_t) |-> !scl; endproperty
    property p_tgt_hold; $rose(scl) && sda_oe_t |-> sda_oe_t [*8]; endproperty
    property p_one_drv; $rose(scl) |-> !(sda_oe_t && sda_oe_m); endproperty
    property p_start_m; s_start |-> sda_oe_m && !sda_oe_t; endproperty
    property p_stop_free; s_stop |-> !sda_oe_t [*8]; endproperty
    property p_scl_low; $rose(scl_oe_m) |-> ##[2:1000] !scl_oe_m; endproperty
    property p_scl_high; $fell(scl_oe_m) |-> !scl_oe_m [*8]; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("lines not released");
    a_tgt_edge: assert property (p_tgt_edge) else $error("target moved data, scl high");
    a_tgt_hold: assert property (p_tgt_hold) else $error("target let go while clock high");
    a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
    a_start_m: assert property (p_start_m) else $error("start not made by master");
    a_stop_free: assert property (p_stop_free) else $error("target drives after stop");
    a_scl_low: assert property (p_scl_low) else $error("clock held low too long");
    a_scl_high: assert property (p_scl_high) else $error("clock high phase too short");
endmodule : chgi2c_props

// ### verif/tb_top.sv
// Bench joining the charger port and its bus master over one link.
// Assumes the design under core/ and the checker in chgi2c_props.sv.
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic rd;
        logic [7:0] r;
        logic [7:0] d;
        logic [7:0] e;
    } chgi2c_row_t;
    logic clk_i;
    logic rst_b_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rdata_o;
    logic int_event_i;
    logic [1:0] ovp_select_o;
    logic high_impedance_o;
    logic hs_mode_o;
    logic [8:0] first9;
    logic [7:0] q;
    int nb;
    int n_fail;
    int check_count;
    chgi2c_row_t rows [8];
    chgi2c_if u_bus ();
    chgi2c_target u_chgi2c_target (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(u_bus.target),
        .int_event_i(int_event_i), .loop_active_i(1'b1), .state_i(8'h35),
        .ovp_select_o(ovp_select_o), .high_impedance_o(high_impedance_o), .hs_mode_o(hs_mode_o));
    chgi2c_master u_chgi2c_master (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(u_bus.master),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    chgi2c_props u_chgi2c_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_oe_m(u_bus.scl_oe_m),
        .sda_oe_m(u_bus.sda_oe_m), .sda_oe_t(u_bus.sda_oe_t), .scl(u_bus.scl), .sda(u_bus.sda));
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : sw_wr
    task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge clk_i);
    endtask : sw_rd
    // One register transfer on the link, status polled with a bound
    task automatic xfer(input logic rd, input logic [7:0] r, input logic [7:0] d,
                        output logic [7:0] v);
        logic [7:0] s;
        s = 8'h01;
        sw_wr(chgi2c_pkg::CR_REG, r);
        sw_wr(chgi2c_pkg::CR_WDATA, d);
        sw_wr(chgi2c_pkg::CR_CMD, {6'h00, rd, 1'b1});
        for (int k = 0; k < 20000 && s[0] !== 1'b0; k++) begin
            sw_rd(chgi2c_pkg::CR_STATUS, s);
        end
        if (s[0] !== 1'b0) begin
            n_fail++;
            conclude();
        end
        chk("nack", {7'h00, s[1]}, 8'h00);
        sw_rd(chgi2c_pkg::CR_RDATA, v);
    endtask : xfer
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // Logs the first nine bits after reset, past the clock pulse that leads the start
    always @(posedge u_bus.scl) begin
        if (rst_b_i === 1'b1) begin
            if (nb >= 1 && nb <= 9) begin
                first9[9 - nb] = u_bus.sda;
            end
            nb++;
        end
    end
    initial begin
        rst_b_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        int_event_i = 1'b0;
        nb = 0;
        n_fail = 0;
        check_count = 0;
        rows[0] = '{1'b1, chgi2c_pkg::OFS_CHIP_IDENTITY, 8'h00, {chgi2c_pkg::SUPPLIER_CODE,
            chgi2c_pkg::PART_NUMBER_BITS, chgi2c_pkg::REVISION}};
        rows[1] = '{1'b0, chgi2c_pkg::OFS_CHARGE_CONTROL_ONE, 8'h6e, 8'h00};
        rows[2] = '{1'b1, chgi2c_pkg::OFS_CHARGE_CONTROL_ONE, 8'h00, 8'h57};
        rows[3] = '{1'b1, chgi2c_pkg::OFS_CHARGE_CONTROL_ONE, 8'h00, 8'h56};
        rows[4] = '{1'b1, 8'h0b, 8'h00, 8'h00};
        rows[5] = '{1'b1, chgi2c_pkg::OFS_STATE, 8'h00, 8'h35};
        rows[6] = '{1'b0, chgi2c_pkg::OFS_BATTERY_CURRENT_SETTING, 8'h5a, 8'h00};
        rows[7] = '{1'b1, chgi2c_pkg::OFS_BATTERY_CURRENT_SETTING, 8'h00, 8'h5a};
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        int_event_i <= 1'b1;
        @(posedge clk_i);
        int_event_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            xfer(rows[i].rd, rows[i].r, rows[i].d, q);
            if (rows[i].rd) begin
                chk("read data", q, rows[i].e);
            end
            if (i == 1) begin
                chk("ovp select", {6'h00, ovp_select_o}, 8'h03);
                chk("high impedance", {7'h00, high_impedance_o}, 8'h01);
            end
        end
        chk("address byte", first9[8:1], {chgi2c_pkg::TARGET_ADDR, 1'b0});
        chk("address ack", {7'h00, first9[0]}, 8'h00);
        xfer(1'b0, chgi2c_pkg::OFS_CHARGE_CONTROL_ONE, 8'h80, q);
        chk("ovp after soft reset", {6'h00, ovp_select_o},
            {6'h00, chgi2c_pkg::CTL1_RESET[2:1]});
        chk("hz after soft reset", {7'h00, high_impedance_o}, 8'h00);
        chk("hs mode", {7'h00, hs_mode_o}, 8'h00);
        xfer(1'b1, chgi2c_pkg::OFS_CHARGE_CONTROL_ONE, 8'h00, q);
        chk("control one after soft reset", q,
            chgi2c_pkg::CTL1_RESET | 8'(1 << chgi2c_pkg::CTL1_LOOP_BIT));
        xfer(1'b1, chgi2c_pkg::OFS_BATTERY_CURRENT_SETTING, 8'h00, q);
        chk("current after soft reset", q, chgi2c_pkg::BATTERY_CURRENT_SETTING_RESET);
        // Leave non-default settings behind, then reset in mid-run
        xfer(1'b0, chgi2c_pkg::OFS_CHARGE_CONTROL_ONE, 8'h44, q);
        chk("ovp before reset", {6'h00, ovp_select_o}, 8'h02);
        rst_b_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("lines idle", {6'h00, u_bus.scl, u_bus.sda}, 8'h03);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("ovp after reset", {6'h00, ovp_select_o},
            {6'h00, chgi2c_pkg::CTL1_RESET[2:1]});
        chk("hz after reset", {7'h00, high_impedance_o}, 8'h00);
        xfer(1'b1, chgi2c_pkg::OFS_CHIP_IDENTITY, 8'h00, q);
        chk("identity after reset", q, {chgi2c_pkg::SUPPLIER_CODE,
            chgi2c_pkg::PART_NUMBER_BITS, chgi2c_pkg::REVISION});
        conclude();
    end
endmodule : tb_top
